// ===== inc/dlm_pkg.sv
package dlm_pkg;

  // **************************************************************
  // Register map, as seen from the debugger
  // **************************************************************
  localparam logic [31:0] DLM_PORT_BASE  = 32'hf0e0_0000;
  localparam int          DLM_BASE_LSB   = 8;
  localparam logic [7:0]  OFS_PORT_CMD   = 8'h00;
  localparam logic [7:0]  OFS_UNLOCK_KEY = 8'h04;
  localparam logic [7:0]  OFS_PORT_STAT  = 8'h08;
  localparam logic [7:0]  OFS_PORT_IDENT = 8'hfc;

  // **************************************************************
  // Field positions
  // **************************************************************
  localparam int CMD_ERASE_BIT  = 0;
  localparam int CMD_RESET_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_LOCK_BIT  = 1;

  // **************************************************************
  // Values after reset and fixed values
  // **************************************************************
  localparam logic [31:0] UNLOCK_KEY_RESET = 32'h0000_0000;
  localparam logic [1:0]  CMD_PEND_RESET   = 2'h0;
  // Lock word reads all ones when erased, i.e. debug open
  localparam logic [31:0] LOCK_WORD_OPEN   = 32'hffff_ffff;

  // **************************************************************
  // Erase targets presented to the memory controller
  // **************************************************************
  localparam logic [1:0] MEM_FLASH_MAIN = 2'h0;
  localparam logic [1:0] MEM_SRAM       = 2'h1;
  localparam logic [1:0] MEM_LOCK_PAGE  = 2'h2;

  // **************************************************************
  // Timing
  // **************************************************************
  localparam int CORE_CLK_KHZ      = 25000;
  localparam int ERASE_TIME_MS     = 40;
  localparam int ERASE_CYCLES      = ERASE_TIME_MS * CORE_CLK_KHZ;
  localparam int WINDOW_CYCLES     = 512;
  localparam int WINDOW_EXT_CYCLES = 8192;

  // Whole device erase sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_WIN,
    ST_FLASH,
    ST_SRAM,
    ST_LOCK_PG,
    ST_HOLD
  } dlm_erase_e;

endpackage : dlm_pkg

// ===== tb/dlm_port_test.sv
`timescale 1ns/1ps
module dlm_port_test
  import dlm_pkg::*;
;
  // ************************************************************
  // Settings and signals
  // ************************************************************
  localparam int          ERASE = 200;
  localparam int          WIN   = 32;
  localparam int          WEXT  = 64;
  localparam logic [31:0] KEY   = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] IDENT = 32'h0a5a_0001; // Arbitrary value
  logic core_clk, dbg_clk, nrst, swd_ext_pattern, mem_done;
  logic dbg_valid, dbg_write, dbg_ready, dbg_fwd, dbg_rvalid_r;
  logic dbg_err_r, mem_erase_req_r, mem_erase_user_lock_r;
  logic core_run_r, dbg_bus_grant_r, system_reset_request_r;
  logic [31:0] dbg_addr, dbg_wdata, dbg_rdata_r, lock_word, rd;
  logic [1:0]  mem_erase_sel_r;
  logic        er, rv, fw;
  logic [1:0]  sel_q[$];
  logic        ulw_q[$];
  int cyc = 0, rel = 0, mcnt = 0, fail_count = 0, total_checks = 0;

  // Unrelated clocks: core 40 ns, link 32 ns with an odd offset
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    dbg_clk = 1'b0;
    #7;
    forever #16 dbg_clk = ~dbg_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  dlm_port #(.UNLOCK_KEY_VALUE(KEY), .PORT_IDENT(IDENT),
    .ERASE_CYC(ERASE), .WIN_CYC(WIN), .WIN_EXT_CYC(WEXT)) uut (
    .core_clk(core_clk), .nrst(nrst), .dbg_clk(dbg_clk),
    .dbg_valid(dbg_valid), .dbg_write(dbg_write), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .dbg_ready(dbg_ready), .dbg_fwd(dbg_fwd),
    .dbg_rvalid_r(dbg_rvalid_r), .dbg_rdata_r(dbg_rdata_r),
    .dbg_err_r(dbg_err_r), .swd_ext_pattern(swd_ext_pattern),
    .debug_lock_word(lock_word), .mem_erase_req_r(mem_erase_req_r),
    .mem_erase_sel_r(mem_erase_sel_r),
    .mem_erase_user_lock_r(mem_erase_user_lock_r),
    .mem_erase_done(mem_done), .core_run_r(core_run_r),
    .dbg_bus_grant_r(dbg_bus_grant_r),
    .system_reset_request_r(system_reset_request_r));

  dlm_probe probe (.dbg_clk(dbg_clk), .dbg_valid(dbg_valid),
    .dbg_write(dbg_write), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
    .dbg_ready(dbg_ready), .dbg_fwd(dbg_fwd),
    .dbg_rvalid_r(dbg_rvalid_r), .dbg_rdata_r(dbg_rdata_r),
    .dbg_err_r(dbg_err_r));

  // Memory controller: each step ends four cycles after it is seen;
  // finishing the lock page reopens the stored lock word
  always @(negedge core_clk) begin
    mem_done <= (mem_erase_req_r === 1'b1) && (mcnt == 4);
    mcnt <= (mem_erase_req_r === 1'b1 && mcnt < 4) ? mcnt + 1 : 0;
    if (mem_erase_req_r === 1'b1 && mcnt == 4) begin
      sel_q.push_back(mem_erase_sel_r);
      ulw_q.push_back(mem_erase_user_lock_r);
      if (mem_erase_sel_r === MEM_LOCK_PAGE) lock_word <= LOCK_WORD_OPEN;
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    probe.xfer(w, a, d, rd, er, rv, fw);
  endtask : acc

  task automatic preg(input logic w, input logic [7:0] o,
                      input logic [31:0] d);
    acc(w, probe.port_addr(o), d);
  endtask : preg

  // Reset held 16 core cycles; pattern shown from reset until two cycles after release
  task automatic do_reset(input logic [31:0] lw, input logic pat);
    @(negedge core_clk);
    nrst = 1'b0;
    lock_word = lw;
    swd_ext_pattern = pat;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    rel = cyc;
    repeat (2) @(negedge core_clk);
    swd_ext_pattern = 1'b0;
    repeat (4) @(negedge dbg_clk);
  endtask : do_reset

  // Cycles from release until code may run, bounded
  task automatic wait_run(output int t);
    int n;
    n = 0;
    while (core_run_r !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    t = cyc - rel;
  endtask : wait_run

  task automatic wait_req(input int lim);
    int n;
    n = 0;
    while (mem_erase_req_r !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_req

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_window();
    int t;
    do_reset(LOCK_WORD_OPEN, 1'b0);
    chk("grant_in_window", 32'h0, dbg_bus_grant_r);
    chk("ready", 32'h1, dbg_ready);
    preg(1'b0, OFS_PORT_IDENT, 32'h0);
    chk("ident", IDENT, rd);
    preg(1'b0, OFS_PORT_STAT, 32'h0);
    chk("status_reset", 32'h0, rd);
    preg(1'b0, OFS_UNLOCK_KEY, 32'h0);
    chk("key_readback", 32'h0, rd);
    acc(1'b0, 32'h2000_0000, 32'h0);
    chk("bus_in_window", 32'h3, {29'h0, fw, rv, er});
    wait_run(t);
    chk("window_len", 32'h1, 32'(t >= WIN && t <= WIN + 6));
    repeat (4) @(negedge core_clk);
    chk("grant_open", 32'h1, dbg_bus_grant_r);
    preg(1'b0, OFS_PORT_IDENT, 32'h0);
    chk("port_closed", 32'h3, {29'h0, fw, rv, er});
    acc(1'b0, 32'h2000_0000, 32'h0);
    chk("bus_forward", 32'h4, {29'h0, fw, rv, er});
  endtask : t_window

  task automatic t_extend();
    int t;
    do_reset(LOCK_WORD_OPEN, 1'b1);
    wait_run(t);
    chk("ext_window", 32'h1, 32'(t >= WEXT && t <= WEXT + 6));
  endtask : t_extend

  task automatic t_locked();
    int t;
    do_reset(32'h0000_0000, 1'b0);
    preg(1'b0, OFS_PORT_STAT, 32'h0);
    chk("lock_flag", 32'h1, 32'(rd[STAT_LOCK_BIT]));
    wait_run(t);
    repeat (4) @(negedge core_clk);
    chk("grant_locked", 32'h0, dbg_bus_grant_r);
    acc(1'b0, 32'h2000_0000, 32'h0);
    chk("bus_blocked", 32'h3, {29'h0, fw, rv, er});
    preg(1'b0, OFS_PORT_IDENT, 32'h0);
    chk("port_locked", {IDENT[30:0], 1'b0}, {rd[30:0], er});
  endtask : t_locked

  task automatic t_erase_locked();
    int t0, n, hi;
    preg(1'b1, OFS_PORT_CMD, 32'h1);
    preg(1'b1, OFS_UNLOCK_KEY, 32'h0);
    repeat (20) @(negedge core_clk);
    chk("erase_no_key", 32'h0, mem_erase_req_r);
    preg(1'b1, OFS_UNLOCK_KEY, KEY);
    preg(1'b1, OFS_PORT_CMD, 32'h1);
    repeat (20) @(negedge core_clk);
    chk("erase_pending", 32'h0, mem_erase_req_r);
    sel_q.delete();
    ulw_q.delete();
    preg(1'b1, OFS_UNLOCK_KEY, 32'h0);
    wait_req(20);
    t0 = cyc;
    chk("erase_start", 32'h1, mem_erase_req_r);
    // Busy needs two link edges to reach the status register
    repeat (4) @(negedge dbg_clk);
    preg(1'b0, OFS_PORT_STAT, 32'h0);
    chk("busy_set", 32'h1, 32'(rd[STAT_BUSY_BIT]));
    while (cyc < t0 + 150) @(negedge core_clk);
    preg(1'b0, OFS_PORT_STAT, 32'h0);
    chk("busy_held", 32'h1, 32'(rd[STAT_BUSY_BIT]));
    n = 0;
    while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 40) begin
      repeat (2) @(negedge core_clk);
      preg(1'b0, OFS_PORT_STAT, 32'h0);
      n++;
    end
    chk("erase_time", 32'h1, 32'(cyc - t0 <= ERASE + 16));
    chk("steps", 32'h3, 32'(sel_q.size()));
    chk("step_order", 32'h6, {26'h0, sel_q[0], sel_q[1], sel_q[2]});
    chk("user_lock", 32'h1, {29'h0, ulw_q[0], ulw_q[1], ulw_q[2]});
    chk("req_released", 32'h0, mem_erase_req_r);
    preg(1'b1, OFS_UNLOCK_KEY, KEY);
    preg(1'b1, OFS_PORT_CMD, 32'h2);
    preg(1'b1, OFS_UNLOCK_KEY, 32'h0);
    hi = 0;
    repeat (30) begin
      @(negedge core_clk);
      hi += int'(system_reset_request_r === 1'b1);
    end
    chk("reset_pulse", 32'h1, 32'(hi));
    do_reset(lock_word, 1'b0);
    preg(1'b0, OFS_PORT_STAT, 32'h0);
    chk("unlocked_after", 32'h0, 32'(rd[STAT_LOCK_BIT]));
  endtask : t_erase_locked

  task automatic t_erase_window();
    int n;
    logic early;
    do_reset(LOCK_WORD_OPEN, 1'b0);
    preg(1'b1, OFS_UNLOCK_KEY, KEY);
    preg(1'b1, OFS_PORT_CMD, 32'h1);
    preg(1'b1, OFS_UNLOCK_KEY, 32'h0);
    early = 1'b0;
    n = 0;
    while (core_run_r !== 1'b1 && n < 200) begin
      early |= (mem_erase_req_r === 1'b1);
      @(negedge core_clk);
      n++;
    end
    chk("erase_in_window", 32'h0, 32'(early));
    wait_req(20);
    chk("erase_at_close", 32'h1, mem_erase_req_r);
  endtask : t_erase_window

  // ************************************************************
  // Verdict, watchdog and main sequence
  // ************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Whole run needs under a thousand core cycles; allow far more
  initial begin
    #1_000_000;
    fail_count++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    swd_ext_pattern = 1'b0;
    lock_word = LOCK_WORD_OPEN;
    mem_done = 1'b0;
    t_window();
    t_extend();
    t_locked();
    t_erase_locked();
    t_erase_window();
    close_out();
  end
endmodule : dlm_port_test

// ===== tb/dlm_probe.sv
`timescale 1ns/1ps
// ************************************************************
// Debugger probe model, link clock domain
// ************************************************************
module dlm_probe
  import dlm_pkg::*;
(
  // Link clock
  input  wire logic        dbg_clk,
  // Request lines
  output logic             dbg_valid,
  output logic             dbg_write,
  output logic [31:0]      dbg_addr,
  output logic [31:0]      dbg_wdata,
  // Answer lines
  input  wire logic        dbg_ready,
  input  wire logic        dbg_fwd,
  input  wire logic        dbg_rvalid_r,
  input  wire logic [31:0] dbg_rdata_r,
  input  wire logic        dbg_err_r
);
  // Idle bus at time zero
  initial begin
    dbg_valid = 1'b0;
    dbg_write = 1'b0;
    dbg_addr  = 32'h0000_0000;
    dbg_wdata = 32'h0000_0000;
  end

  // Port register address seen through the access port
  function automatic logic [31:0] port_addr(input logic [7:0] o);
    return DLM_PORT_BASE | {24'h00_0000, o};
  endfunction : port_addr

  // One access; released lines show the inverse of the last value so
  // a design that samples outside the request cannot reuse it
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er, output logic rv,
                      output logic fw);
    int n;
    @(negedge dbg_clk);
    dbg_valid = 1'b1;
    dbg_write = wr;
    dbg_addr  = a;
    dbg_wdata = d;
    #2 fw = dbg_fwd;
    n = 0;
    // Hold the request until ready is seen at a rising edge
    do begin
      @(posedge dbg_clk);
      n++;
    end while (dbg_ready !== 1'b1 && n < 8);
    @(negedge dbg_clk);
    rv = dbg_rvalid_r;
    rd = dbg_rdata_r;
    er = dbg_err_r;
    dbg_valid = 1'b0;
    dbg_addr  = ~a;
    dbg_wdata = ~d;
  endtask : xfer
endmodule : dlm_probe

// ===== verilog/dlm_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Cleared lock word locks debug after reset
// - Locked: link stays up, core/bus blocked
// - Port registers reachable from debugger only
// - Port sits at base 0xf0e00000
// - After reset only port registers reachable
// - Locked: block persists after code starts
// - Unlocked: port closes, bus granted
// - Commands pend until key invalidated
// - Erase flash, then SRAM, then lock page
// - Erase lasts 40 ms, unlocks next reset
// - User data kept, its lock word erased
// - Unlocked erase starts when window closes
// - Command bit 0 starts whole erase
// - Command bits need valid key
module dlm_port
  import dlm_pkg::*;
#(
  parameter logic [31:0] UNLOCK_KEY_VALUE = 32'h1234_5678, // Arbitrary
  parameter logic [31:0] PORT_IDENT       = 32'h0a5a_0001, // Arbitrary
  parameter int          ERASE_CYC        = ERASE_CYCLES,
  parameter int          WIN_CYC          = WINDOW_CYCLES,
  parameter int          WIN_EXT_CYC      = WINDOW_EXT_CYCLES
) (
  // Core clock and system reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Debug link clock
  input  wire logic        dbg_clk,
  // Debugger access, link domain
  input  wire logic        dbg_valid,
  input  wire logic        dbg_write,
  input  wire logic [31:0] dbg_addr,
  input  wire logic [31:0] dbg_wdata,
  output logic             dbg_ready,
  output logic             dbg_fwd,
  output logic             dbg_rvalid_r,
  output logic [31:0]      dbg_rdata_r,
  output logic             dbg_err_r,
  // Pins and flash strap
  input  wire logic        swd_ext_pattern,
  input  wire logic [31:0] debug_lock_word,
  // Memory erase handshake, core domain
  output logic             mem_erase_req_r,
  output logic [1:0]       mem_erase_sel_r,
  output logic             mem_erase_user_lock_r,
  input  wire logic        mem_erase_done,
  // System control, core domain
  output logic             core_run_r,
  output logic             dbg_bus_grant_r,
  output logic             system_reset_request_r
);

  localparam logic [31:0] ERASE_LIM = ERASE_CYC[31:0];
  localparam logic [31:0] WIN_LIM   = WIN_CYC[31:0];
  localparam logic [31:0] WIN_XLIM  = WIN_EXT_CYC[31:0];

  // **************************************************************
  // Crossings
  // **************************************************************
  logic [1:0]  cmd_tog_r, cmd_tog_nxt;     // Link side command toggles
  logic [1:0]  cmd_tog_s;                  // Toggles in core domain
  logic [1:0]  cmd_seen_r, cmd_seen_nxt;   // Last toggles taken
  logic        ext_s;                      // Extension pattern level
  logic [3:0]  stat_s;                     // Grant, open, locked, busy
  logic        erase_busy;                 // Erase in progress
  logic        locked_r, locked_nxt;       // Debug lock state
  logic        window_r, window_nxt;       // Access window open

  dlm_sync #(.W(2)) u_cmd_sync (
    .clk  (core_clk),
    .nrst (nrst),
    .d    (cmd_tog_r),
    .q    (cmd_tog_s)
  );

  dlm_sync #(.W(1)) u_ext_sync (
    .clk  (core_clk),
    .nrst (nrst),
    .d    (swd_ext_pattern),
    .q    (ext_s)
  );

  // Grant travels too: the synchroniser resets to zero, so nothing is
  // forwarded before the core side has settled lock and window
  dlm_sync #(.W(4)) u_stat_sync (
    .clk  (dbg_clk),
    .nrst (nrst),
    .d    ({dbg_bus_grant_r, window_r | locked_r, locked_r, erase_busy}),
    .q    (stat_s)
  );

  // **************************************************************
  // Link domain: decode, key and pending commands
  // **************************************************************
  logic [31:0] key_r, key_nxt;             // Command unlock key
  logic [1:0]  pend_r, pend_nxt;           // Commands awaiting launch
  logic        rvalid_nxt, err_nxt;
  logic [31:0] rdata_nxt;
  logic        port_hit, port_open, key_ok, wr_cmd, wr_key;
  logic [7:0]  ofs;

  assign ofs       = dbg_addr[7:0];
  // Base decode on the upper address bits
  assign port_hit  = dbg_addr[31:DLM_BASE_LSB] ==
                     DLM_PORT_BASE[31:DLM_BASE_LSB];
  // Port open in the window, or for good while locked
  assign port_open = stat_s[2];
  assign key_ok    = key_r == UNLOCK_KEY_VALUE;
  // Accesses come only from the debugger port, never the core
  assign wr_cmd    = dbg_valid && dbg_write && port_hit && port_open &&
                     ofs == OFS_PORT_CMD;
  assign wr_key    = dbg_valid && dbg_write && port_hit && port_open &&
                     ofs == OFS_UNLOCK_KEY;
  // Every access completes in one link cycle
  assign dbg_ready = 1'b1;
  // Bus access passes only when granted and not aimed at the port
  assign dbg_fwd   = dbg_valid && !port_hit && stat_s[3] &&
                     !stat_s[2];

  // Next state of the link registers
  always_comb begin
    key_nxt     = key_r;
    pend_nxt    = pend_r;
    cmd_tog_nxt = cmd_tog_r;
    rvalid_nxt  = dbg_valid && !dbg_fwd;
    err_nxt     = 1'b0;
    rdata_nxt   = 32'h0000_0000;
    // Upper command bits are ignored; debugger keeps them zero
    if (wr_cmd && key_ok) begin
      pend_nxt = pend_r | dbg_wdata[1:0];
    end
    if (wr_key) begin
      key_nxt = dbg_wdata;
      // Key invalidated: launch what is pending
      if (dbg_wdata != UNLOCK_KEY_VALUE) begin
        cmd_tog_nxt = cmd_tog_r ^ pend_r;
        pend_nxt    = CMD_PEND_RESET;
      end
    end
    if (dbg_valid && !dbg_fwd) begin
      if (!port_hit || !port_open) begin
        // Blocked by lock or window
        err_nxt = 1'b1;
      end else if (!dbg_write) begin
        case (ofs)
          OFS_PORT_STAT: begin
            rdata_nxt[STAT_BUSY_BIT] = stat_s[0];
            rdata_nxt[STAT_LOCK_BIT] = stat_s[1];
          end
          OFS_PORT_IDENT: rdata_nxt = PORT_IDENT;
          // Command and key are write only
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Link registers
  always_ff @(posedge dbg_clk or negedge nrst) begin
    if (!nrst) begin
      key_r        <= UNLOCK_KEY_RESET;
      pend_r       <= CMD_PEND_RESET;
      cmd_tog_r    <= 2'h0;
      dbg_rvalid_r <= 1'b0;
      dbg_err_r    <= 1'b0;
      dbg_rdata_r  <= 32'h0000_0000;
    end else begin
      key_r        <= key_nxt;
      pend_r       <= pend_nxt;
      cmd_tog_r    <= cmd_tog_nxt;
      dbg_rvalid_r <= rvalid_nxt;
      dbg_err_r    <= err_nxt;
      dbg_rdata_r  <= rdata_nxt;
    end
  end

  // **************************************************************
  // Core domain: lock sampling and access window
  // **************************************************************
  logic        sampled_r, sampled_nxt;     // Lock word taken
  logic        ext_r, ext_nxt;             // Window extended
  logic [31:0] win_cnt_r, win_cnt_nxt;     // Window age
  logic        run_nxt, grant_nxt;
  logic [1:0]  cmd_new;

  // Lock word is read one edge after release, not under reset
  always_comb begin
    sampled_nxt = 1'b1;
    locked_nxt  = locked_r;
    ext_nxt     = ext_r | (window_r & ext_s);
    win_cnt_nxt = win_cnt_r;
    window_nxt  = window_r;
    if (!sampled_r) begin
      locked_nxt = debug_lock_word != LOCK_WORD_OPEN;
    end
    if (window_r) begin
      win_cnt_nxt = win_cnt_r + 32'h0000_0001;
      if (win_cnt_r >= (ext_nxt ? WIN_XLIM : WIN_LIM)) begin
        window_nxt = 1'b0;
      end
    end
    // Code runs once the window closes
    run_nxt   = !window_nxt;
    // Grant only when unlocked and past the window
    grant_nxt = !window_nxt && !locked_nxt;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sampled_r       <= 1'b0;
      locked_r        <= 1'b1;
      ext_r           <= 1'b0;
      win_cnt_r       <= 32'h0000_0000;
      window_r        <= 1'b1;
      core_run_r      <= 1'b0;
      dbg_bus_grant_r <= 1'b0;
    end else begin
      sampled_r       <= sampled_nxt;
      locked_r        <= locked_nxt;
      ext_r           <= ext_nxt;
      win_cnt_r       <= win_cnt_nxt;
      window_r        <= window_nxt;
      core_run_r      <= run_nxt;
      dbg_bus_grant_r <= grant_nxt;
    end
  end

  // **************************************************************
  // Core domain: erase sequencer and reset request
  // **************************************************************
  dlm_erase_e  st_r, st_nxt;               // Sequencer state
  logic [31:0] tmr_r, tmr_nxt;             // Time since erase start
  logic        req_nxt, ulw_nxt, srst_nxt;
  logic [1:0]  sel_nxt;

  assign cmd_new    = cmd_tog_s ^ cmd_seen_r;
  assign erase_busy = st_r != ST_IDLE && st_r != ST_WAIT_WIN;

  // Each step holds its request until the controller reports done
  always_comb begin
    st_nxt       = st_r;
    cmd_seen_nxt = cmd_tog_s;
    tmr_nxt      = (tmr_r < ERASE_LIM) ? tmr_r + 32'h0000_0001 : tmr_r;
    req_nxt      = mem_erase_req_r;
    sel_nxt      = mem_erase_sel_r;
    ulw_nxt      = 1'b0;
    srst_nxt     = cmd_new[CMD_RESET_BIT];
    case (st_r)
      ST_IDLE: begin
        tmr_nxt = 32'h0000_0000;
        if (cmd_new[CMD_ERASE_BIT]) begin
          st_nxt = ST_WAIT_WIN;
        end
      end
      ST_WAIT_WIN: begin
        // Erase time counts from the first step, not from the wait
        tmr_nxt = 32'h0000_0000;
        // Unlocked part waits for the window to close
        if (locked_r || !window_r) begin
          st_nxt  = ST_FLASH;
          req_nxt = 1'b1;
          sel_nxt = MEM_FLASH_MAIN;
        end
      end
      ST_FLASH: begin
        if (mem_erase_done) begin
          st_nxt  = ST_SRAM;
          sel_nxt = MEM_SRAM;
        end
      end
      ST_SRAM: begin
        if (mem_erase_done) begin
          st_nxt  = ST_LOCK_PG;
          sel_nxt = MEM_LOCK_PAGE;
          ulw_nxt = 1'b1;
        end
      end
      ST_LOCK_PG: begin
        // Lock page erase also clears the user page lock word only
        ulw_nxt = 1'b1;
        if (mem_erase_done) begin
          st_nxt  = ST_HOLD;
          req_nxt = 1'b0;
          ulw_nxt = 1'b0;
        end
      end
      ST_HOLD: begin
        // Busy holds until the full erase time has passed
        if (tmr_r >= ERASE_LIM) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r                   <= ST_IDLE;
      cmd_seen_r             <= 2'h0;
      tmr_r                  <= 32'h0000_0000;
      mem_erase_req_r        <= 1'b0;
      mem_erase_sel_r        <= MEM_FLASH_MAIN;
      mem_erase_user_lock_r  <= 1'b0;
      system_reset_request_r <= 1'b0;
    end else begin
      st_r                   <= st_nxt;
      cmd_seen_r             <= cmd_seen_nxt;
      tmr_r                  <= tmr_nxt;
      mem_erase_req_r        <= req_nxt;
      mem_erase_sel_r        <= sel_nxt;
      mem_erase_user_lock_r  <= ulw_nxt;
      system_reset_request_r <= srst_nxt;
    end
  end

  // **************************************************************
  // Checks
  // **************************************************************
  sequence s_flash_step;
    st_r == ST_FLASH && mem_erase_done;
  endsequence

  sequence s_sram_start;
    st_r == ST_SRAM && mem_erase_sel_r == MEM_SRAM;
  endsequence

  a_lock_blocks_bus: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sampled_r && locked_r |=> !dbg_bus_grant_r)
    else $error("bus granted while locked");

  a_window_no_grant: assert property (
    @(posedge core_clk) disable iff (!nrst)
    window_r |-> !dbg_bus_grant_r && !core_run_r)
    else $error("grant or run inside window");

  a_unlocked_grant: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sampled_r && !locked_r && !window_r |=> dbg_bus_grant_r)
    else $error("unlocked part not granted");

  a_erase_waits_win: assert property (
    @(posedge core_clk) disable iff (!nrst)
    window_r && !locked_r |-> !mem_erase_req_r)
    else $error("erase began inside window");

  a_erase_order: assert property (
    @(posedge core_clk) disable iff (!nrst)
    s_flash_step |=> s_sram_start)
    else $error("sram step did not follow flash");

  a_busy_covers_req: assert property (
    @(posedge core_clk) disable iff (!nrst)
    mem_erase_req_r |-> erase_busy)
    else $error("erase request while not busy");

  a_erase_min_time: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $fell(erase_busy) |-> $past(tmr_r) >= ERASE_LIM)
    else $error("erase ended before its time");

  a_user_lock_word: assert property (
    @(posedge core_clk) disable iff (!nrst)
    mem_erase_user_lock_r |-> mem_erase_sel_r == MEM_LOCK_PAGE)
    else $error("user lock word erased off lock page");

  a_cmd_needs_key: assert property (
    @(posedge dbg_clk) disable iff (!nrst)
    wr_cmd && !key_ok && !wr_key |=> $stable(pend_r))
    else $error("command taken without valid key");

  a_pend_until_key: assert property (
    @(posedge dbg_clk) disable iff (!nrst)
    !wr_key |=> $stable(cmd_tog_r))
    else $error("command launched before key cleared");

  a_fwd_blocked: assert property (
    @(posedge dbg_clk) disable iff (!nrst)
    stat_s[1] |-> !dbg_fwd)
    else $error("access forwarded while locked");

endmodule : dlm_port

// ===== verilog/dlm_sync.sv
`timescale 1ns/1ps
module dlm_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;  // First stage, read by the second only

  // **************************************************************
  // Two flop level synchroniser
  // **************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : dlm_sync
